// [hw/fmbc_pkg.sv]
// Constants and types shared by the move and branch control block.
package fmbc_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int FPR_W   = 64;
   localparam int HALF_W  = 32;
   localparam int GPR_W   = 64;
   localparam int PC_W    = 64;
   localparam int OFFS_W  = 16;
   localparam int REGA_W  = 5;
   localparam int CC_N    = 8;
   localparam int CCSEL_W = 3;
   localparam int CSR_W   = 32;

   // ************************************************************
   // Control/status register fields
   // ************************************************************
   localparam int CSR_CC0_POS    = 23;
   localparam int CSR_CC17_LO    = 25;
   localparam int CSR_CC17_HI    = 31;
   localparam int CSR_SIGN_POS   = 19;
   localparam logic [CSR_W-1:0] CSR_RESET = 32'h0000_0000;

   // ************************************************************
   // Operand formats
   // ************************************************************
   typedef enum logic [2:0]
   {
      FMT_SINGLE,
      FMT_DOUBLE,
      FMT_WORD,
      FMT_LONG,
      FMT_PAIRED
   } fmbc_fmt_t;

   // ************************************************************
   // Operations
   // ************************************************************
   typedef enum logic [4:0]
   {
      OP_NONE,
      OP_FP_MOVE,
      OP_FP_ABS,
      OP_FP_NEG,
      OP_MOVE_CC_FALSE,
      OP_MOVE_CC_TRUE,
      OP_MOVE_GPR_NONZERO,
      OP_MOVE_GPR_ZERO,
      OP_BRANCH_CC_FALSE,
      OP_BRANCH_CC_TRUE,
      OP_BRANCH_LIKELY_FALSE,
      OP_BRANCH_LIKELY_TRUE,
      OP_GPR_MOVE_CC_FALSE,
      OP_GPR_MOVE_CC_TRUE,
      OP_ALIGN_VARIABLE,
      OP_PAIR_LL,
      OP_PAIR_LU,
      OP_PAIR_UL,
      OP_PAIR_UU,
      OP_COMPARE_WRITE,
      OP_CSR_WRITE
   } fmbc_op_t;

   // Byte offset of the paired align selector that picks the upper word.
   localparam logic [2:0] ALIGN_HALF_OFFS = 3'h4;

endpackage : fmbc_pkg

// [hw/fmbc_cc_file.sv]
// Condition code file mapped onto the control/status register.
`timescale 1ns/1ps
module fmbc_cc_file
   import fmbc_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // Compare write
   input  wire logic                 cmp_we,
   input  wire logic [CCSEL_W-1:0]   cmp_sel,
   input  wire logic                 cmp_val,
   // Whole register write
   input  wire logic                 csr_we,
   input  wire logic [CSR_W-1:0]     csr_wdata,
   // State
   output logic      [CSR_W-1:0]     csr_q,
   output logic      [CC_N-1:0]      cc_bits
);

   logic [CSR_W-1:0] csr_d;
   logic [CSR_W-1:0] cmp_mask;

   // Bit 0 and bits 1..7 live in separate fields.
   assign cc_bits = {csr_q[CSR_CC17_HI:CSR_CC17_LO], csr_q[CSR_CC0_POS]};
   assign cmp_mask = (cmp_sel == 3'h0) ? (32'h1 << CSR_CC0_POS)
                   : (32'h1 << (CSR_CC17_LO + int'(cmp_sel) - 1)); // [RQ14]

   always_comb
   begin
      csr_d = csr_q;
      if (csr_we)
      begin
         csr_d = csr_wdata;
      end
      if (cmp_we)
      begin
         csr_d = cmp_val ? (csr_d | cmp_mask) : (csr_d & ~cmp_mask); // [RQ13]
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         csr_q <= CSR_RESET;
      end
      else
      begin
         csr_q <= csr_d;
      end
   end

endmodule : fmbc_cc_file

// [hw/fmbc_pair_unit.sv]
// Paired-single align and merge datapath.
`timescale 1ns/1ps
module fmbc_pair_unit
   import fmbc_pkg::*;
(
   // Operation
   input  wire fmbc_op_t             op,
   input  wire logic [2:0]           align_offs,
   // Operands
   input  wire logic [FPR_W-1:0]     src_a,
   input  wire logic [FPR_W-1:0]     src_b,
   // Result
   output logic      [FPR_W-1:0]     result,
   output logic                      valid
);

   logic [HALF_W-1:0] a_hi;
   logic [HALF_W-1:0] a_lo;
   logic [HALF_W-1:0] b_hi;
   logic [HALF_W-1:0] b_lo;
   logic              align_hi;

   assign a_hi = src_a[FPR_W-1:HALF_W];
   assign a_lo = src_a[HALF_W-1:0];
   assign b_hi = src_b[FPR_W-1:HALF_W];
   assign b_lo = src_b[HALF_W-1:0];
   assign align_hi = (align_offs == ALIGN_HALF_OFFS);

   always_comb
   begin
      valid = 1'b1;
      case (op)
         OP_PAIR_LL: result = {a_lo, b_lo}; // [RQ17]
         OP_PAIR_LU: result = {a_lo, b_hi}; // [RQ17]
         OP_PAIR_UL: result = {a_hi, b_lo}; // [RQ17]
         OP_PAIR_UU: result = {a_hi, b_hi}; // [RQ17]
         OP_ALIGN_VARIABLE:
            result = align_hi ? {a_lo, b_hi} : src_a; // [RQ16]
         default:
         begin
            result = '0;
            valid  = 1'b0;
         end
      endcase
   end

endmodule : fmbc_pair_unit

// [hw/fmbc_top.sv]
// Move, conditional move, branch and pair control for the floating point unit.
//
// Contract
// RQ1 - Copy formatted values between floating registers.
// RQ2 - Issuer uses the move matching operand format.
// RQ3 - Sign-only abs and negate when control set.
// RQ4 - Conditional move always leaves named format.
// RQ5 - Wrong prior format gives undefined result.
// RQ6 - Move on code false or true.
// RQ7 - Move on general register nonzero or zero.
// RQ8 - Branches use PC-relative target and compare code.
// RQ9 - One delay slot executes when taken.
// RQ10 - Ordinary branch runs slot when not taken.
// RQ11 - Likely branch nullifies slot when not taken.
// RQ12 - Software should avoid likely branches.
// RQ13 - Eight condition code bits exist.
// RQ14 - Code bit 0 separate from bits 1..7.
// RQ15 - General register move conditioned on code.
// RQ16 - Variable align extracts an aligned pair.
// RQ17 - Four pair merge operations.
// RQ18 - Branch taken on false clear, true set.
// RQ19 - Paired forms act on both halves.
// RQ20 - Three-bit selector picks the code bit.
`timescale 1ns/1ps
module fmbc_top
   import fmbc_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 nrst,
   // Issued instruction
   input  wire logic                 issue_valid,
   input  wire fmbc_op_t             issue_op,
   input  wire fmbc_fmt_t            issue_fmt,
   input  wire logic [CCSEL_W-1:0]   issue_cc_sel,
   input  wire logic [REGA_W-1:0]    issue_dst,
   input  wire logic [2:0]           issue_align_offs,
   input  wire logic [PC_W-1:0]      issue_pc,
   input  wire logic [OFFS_W-1:0]    issue_offset,
   // Operands
   input  wire logic [FPR_W-1:0]     fpr_src_a,
   input  wire logic [FPR_W-1:0]     fpr_src_b,
   input  wire logic [FPR_W-1:0]     fpr_dst_old,
   input  wire logic [GPR_W-1:0]     gpr_test,
   input  wire logic [GPR_W-1:0]     gpr_src,
   input  wire logic [GPR_W-1:0]     gpr_dst_old,
   // Compare and control writes
   input  wire logic                 cmp_we,
   input  wire logic [CCSEL_W-1:0]   cmp_sel,
   input  wire logic                 cmp_val,
   input  wire logic                 csr_we,
   input  wire logic [CSR_W-1:0]     csr_wdata,
   // Floating register write back
   output logic                      fpr_we,
   output logic      [REGA_W-1:0]    fpr_waddr,
   output logic      [FPR_W-1:0]     fpr_wdata,
   output fmbc_fmt_t                 fpr_wfmt,
   // General register write back
   output logic                      gpr_we,
   output logic      [REGA_W-1:0]    gpr_waddr,
   output logic      [GPR_W-1:0]     gpr_wdata,
   // Branch outcome
   output logic                      br_valid,
   output logic                      br_taken,
   output logic      [PC_W-1:0]      br_target,
   output logic                      slot_nullify,
   // State
   output logic      [CSR_W-1:0]     csr_out
);

   // ************************************************************
   // Reset synchroniser
   // ************************************************************
   logic rst_s1_q;
   logic rst_n;

   // Reset takes hold at once but lets go only after two clock edges,
   // so every flop leaves reset on a clean edge.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   // ************************************************************
   // Functions
   // ************************************************************
   function automatic logic [HALF_W-1:0] sign_op
      (input logic [HALF_W-1:0] v, input logic neg);
      sign_op = neg ? {~v[HALF_W-1], v[HALF_W-2:0]}
                    : {1'b0, v[HALF_W-2:0]};
   endfunction : sign_op

   function automatic logic [FPR_W-1:0] sign_fmt
      (input logic [FPR_W-1:0] v, input fmbc_fmt_t f, input logic neg);
      logic [FPR_W-1:0] r;
      r = v;
      if (f == FMT_PAIRED)
      begin
         r = {sign_op(v[FPR_W-1:HALF_W], neg),
              sign_op(v[HALF_W-1:0], neg)}; // [RQ19]
      end
      else if (f == FMT_SINGLE)
      begin
         r = {v[FPR_W-1:HALF_W], sign_op(v[HALF_W-1:0], neg)};
      end
      else
      begin
         r = neg ? {~v[FPR_W-1], v[FPR_W-2:0]} : {1'b0, v[FPR_W-2:0]};
      end
      sign_fmt = r;
   endfunction : sign_fmt

   // ************************************************************
   // Condition codes
   // ************************************************************
   logic [CSR_W-1:0] csr_q;
   logic [CC_N-1:0]  cc_bits;
   logic             cc_sel_bit;
   logic             sign_only;

   fmbc_cc_file u_cc
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .cmp_we    (cmp_we),
      .cmp_sel   (cmp_sel),
      .cmp_val   (cmp_val),
      .csr_we    (csr_we),
      .csr_wdata (csr_wdata),
      .csr_q     (csr_q),
      .cc_bits   (cc_bits)
   );

   assign cc_sel_bit = cc_bits[issue_cc_sel]; // [RQ20]
   assign sign_only  = csr_q[CSR_SIGN_POS];

   // ************************************************************
   // Pair unit
   // ************************************************************
   logic [FPR_W-1:0] pair_result;
   logic             pair_valid;

   fmbc_pair_unit u_pair
   (
      .op         (issue_op),
      .align_offs (issue_align_offs),
      .src_a      (fpr_src_a),
      .src_b      (fpr_src_b),
      .result     (pair_result),
      .valid      (pair_valid)
   );

   // ************************************************************
   // Decode
   // ************************************************************
   logic gpr_nz;
   logic cmove_cc;
   logic cmove_gpr;
   logic cmove_take;
   logic is_branch;
   logic is_likely;
   logic br_cond;
   logic is_gmove;
   logic gmove_take;
   logic sign_move;
   logic [PC_W-1:0]  target_d;

   assign gpr_nz    = (gpr_test != '0);
   assign cmove_cc  = (issue_op == OP_MOVE_CC_FALSE)
                    | (issue_op == OP_MOVE_CC_TRUE);
   assign cmove_gpr = (issue_op == OP_MOVE_GPR_NONZERO)
                    | (issue_op == OP_MOVE_GPR_ZERO);
   assign cmove_take =
        ((issue_op == OP_MOVE_CC_FALSE) & ~cc_sel_bit)   // [RQ6]
      | ((issue_op == OP_MOVE_CC_TRUE) & cc_sel_bit)     // [RQ6]
      | ((issue_op == OP_MOVE_GPR_NONZERO) & gpr_nz)     // [RQ7]
      | ((issue_op == OP_MOVE_GPR_ZERO) & ~gpr_nz);      // [RQ7]

   assign is_branch = (issue_op == OP_BRANCH_CC_FALSE)
                    | (issue_op == OP_BRANCH_CC_TRUE)
                    | (issue_op == OP_BRANCH_LIKELY_FALSE)
                    | (issue_op == OP_BRANCH_LIKELY_TRUE);
   assign is_likely = (issue_op == OP_BRANCH_LIKELY_FALSE)
                    | (issue_op == OP_BRANCH_LIKELY_TRUE);
   assign br_cond =
        ((issue_op == OP_BRANCH_CC_FALSE
          || issue_op == OP_BRANCH_LIKELY_FALSE) & ~cc_sel_bit) // [RQ18]
      | ((issue_op == OP_BRANCH_CC_TRUE
          || issue_op == OP_BRANCH_LIKELY_TRUE) & cc_sel_bit);  // [RQ18]

   // Target is relative to the delay-slot address, word offset.
   assign target_d = issue_pc + PC_W'(4)
                   + {{(PC_W-OFFS_W-2){issue_offset[OFFS_W-1]}},
                      issue_offset, 2'b00}; // [RQ8]

   assign is_gmove   = (issue_op == OP_GPR_MOVE_CC_FALSE)
                     | (issue_op == OP_GPR_MOVE_CC_TRUE);
   assign gmove_take =
        ((issue_op == OP_GPR_MOVE_CC_FALSE) & ~cc_sel_bit)
      | ((issue_op == OP_GPR_MOVE_CC_TRUE) & cc_sel_bit); // [RQ15]

   assign sign_move = (issue_op == OP_FP_ABS) | (issue_op == OP_FP_NEG);

   // ************************************************************
   // Floating result selection
   // ************************************************************
   logic              fpr_we_d;
   logic [FPR_W-1:0]  fpr_wdata_d;

   always_comb
   begin
      fpr_we_d    = 1'b0;
      fpr_wdata_d = fpr_src_a;
      if (issue_valid)
      begin
         if (issue_op == OP_FP_MOVE)
         begin
            fpr_we_d = 1'b1; // [RQ1] [RQ19]
         end
         else if (sign_move && sign_only)
         begin
            fpr_we_d    = 1'b1;
            fpr_wdata_d = sign_fmt(fpr_src_a, issue_fmt,
                                   issue_op == OP_FP_NEG); // [RQ3]
         end
         else if (cmove_cc || cmove_gpr)
         begin
            // The destination is rewritten either way, tagged with the
            // named format; an old value of another format is passed
            // through unchanged and is therefore undefined. [RQ5]
            fpr_we_d    = 1'b1; // [RQ4]
            fpr_wdata_d = cmove_take ? fpr_src_a : fpr_dst_old;
         end
         else if (pair_valid)
         begin
            fpr_we_d    = 1'b1;
            fpr_wdata_d = pair_result;
         end
      end
   end

   // ************************************************************
   // Output registers
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fpr_we       <= 1'b0;
         fpr_waddr    <= '0;
         fpr_wdata    <= '0;
         fpr_wfmt     <= FMT_SINGLE;
         gpr_we       <= 1'b0;
         gpr_waddr    <= '0;
         gpr_wdata    <= '0;
         br_valid     <= 1'b0;
         br_taken     <= 1'b0;
         br_target    <= '0;
         slot_nullify <= 1'b0;
      end
      else
      begin
         fpr_we    <= fpr_we_d;
         fpr_waddr <= issue_dst;
         fpr_wdata <= fpr_wdata_d;
         fpr_wfmt  <= pair_valid ? FMT_PAIRED : issue_fmt;
         gpr_we    <= issue_valid & is_gmove;
         gpr_waddr <= issue_dst;
         gpr_wdata <= gmove_take ? gpr_src : gpr_dst_old; // [RQ15]
         br_valid  <= issue_valid & is_branch;
         br_taken  <= issue_valid & is_branch & br_cond; // [RQ9]
         br_target <= target_d;
         // Ordinary branches never nullify; likely ones only untaken.
         slot_nullify <= issue_valid & is_likely & ~br_cond; // [RQ10] [RQ11]
      end
   end

   // The register copy is sent out through a flop of its own, one
   // cycle behind the condition code file.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         csr_out <= CSR_RESET;
      end
      else
      begin
         csr_out <= csr_q;
      end
   end

endmodule : fmbc_top

// [tb/fmbc_top_chk.sv]
// Concurrent checks on the ports of the move and branch control block.
`timescale 1ns/1ps
module fmbc_top_chk
   import fmbc_pkg::*;
(
   // Clock and reset
   input wire logic               clk,
   input wire logic               nrst,
   // Issue and operands
   input wire logic               issue_valid,
   input wire fmbc_op_t           issue_op,
   input wire logic [PC_W-1:0]    issue_pc,
   input wire logic [OFFS_W-1:0]  issue_offset,
   input wire logic [FPR_W-1:0]   fpr_src_a,
   input wire logic [FPR_W-1:0]   fpr_src_b,
   input wire logic [FPR_W-1:0]   fpr_dst_old,
   input wire logic [GPR_W-1:0]   gpr_test,
   // Code writes
   input wire logic               cmp_we,
   input wire logic [CCSEL_W-1:0] cmp_sel,
   input wire logic               cmp_val,
   input wire logic               csr_we,
   // Results
   input wire logic               fpr_we,
   input wire logic [FPR_W-1:0]   fpr_wdata,
   input wire logic               gpr_we,
   input wire logic               br_valid,
   input wire logic               br_taken,
   input wire logic [PC_W-1:0]    br_target,
   input wire logic               slot_nullify,
   input wire logic [CSR_W-1:0]   csr_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_move;
      issue_valid && issue_op == OP_FP_MOVE;
   endsequence
   sequence s_branch;
      issue_valid && issue_op inside {[OP_BRANCH_CC_FALSE:
                                       OP_BRANCH_LIKELY_TRUE]};
   endsequence
   sequence s_ordinary;
      issue_valid && issue_op inside {OP_BRANCH_CC_FALSE, OP_BRANCH_CC_TRUE};
   endsequence
   sequence s_cmp(logic zero_sel);
      cmp_we && !csr_we && ((cmp_sel == 3'h0) == zero_sel);
   endsequence

   property p_move;
      s_move |=> fpr_we && fpr_wdata == $past(fpr_src_a);
   endproperty
   a_move: assert property (p_move) else $error("move result wrong");
   property p_gpr_zero;
      issue_valid && issue_op == OP_MOVE_GPR_ZERO |=> fpr_we && fpr_wdata ==
         ($past(gpr_test) == '0 ? $past(fpr_src_a) : $past(fpr_dst_old));
   endproperty
   a_gpr_zero: assert property (p_gpr_zero)
      else $error("zero move wrong");
   property p_pair_lu;
      issue_valid && issue_op == OP_PAIR_LU |=> fpr_wdata ==
         {$past(fpr_src_a[31:0]), $past(fpr_src_b[63:32])};
   endproperty
   a_pair_lu: assert property (p_pair_lu)
      else $error("pair merge wrong");
   property p_target;
      s_branch |=> br_valid && br_target == $past(issue_pc) + 64'h4 +
         {{46{$past(issue_offset[15])}}, $past(issue_offset), 2'b00};
   endproperty
   a_target: assert property (p_target)
      else $error("branch target wrong");
   property p_nullify;
      slot_nullify |-> br_valid && !br_taken && $past(issue_op) inside
         {OP_BRANCH_LIKELY_FALSE, OP_BRANCH_LIKELY_TRUE};
   endproperty
   a_nullify: assert property (p_nullify) else $error("bad nullify");
   property p_ordinary;
      s_ordinary |=> br_valid && !slot_nullify;
   endproperty
   a_ordinary: assert property (p_ordinary)
      else $error("slot dropped");
   property p_gpr_we;
      gpr_we |-> $past(issue_valid) && $past(issue_op) inside
         {OP_GPR_MOVE_CC_FALSE, OP_GPR_MOVE_CC_TRUE};
   endproperty
   a_gpr_we: assert property (p_gpr_we)
      else $error("stray gpr write");
   property p_cc0;
      s_cmp(1'b1) |-> ##2 csr_out[CSR_CC0_POS] == $past(cmp_val, 2);
   endproperty
   a_cc0: assert property (p_cc0) else $error("code 0 field wrong");
   property p_cc17;
      s_cmp(1'b0) |-> ##2
         csr_out[CSR_CC17_LO - 1 + $past(cmp_sel, 2)] == $past(cmp_val, 2);
   endproperty
   a_cc17: assert property (p_cc17) else $error("code field wrong");
endmodule : fmbc_top_chk

bind fmbc_top fmbc_top_chk fmbc_top_chk_inst (
   .clk(clk), .nrst(nrst), .issue_valid(issue_valid), .issue_op(issue_op),
   .issue_pc(issue_pc), .issue_offset(issue_offset),
   .fpr_src_a(fpr_src_a), .fpr_src_b(fpr_src_b), .fpr_dst_old(fpr_dst_old),
   .gpr_test(gpr_test), .cmp_we(cmp_we), .cmp_sel(cmp_sel),
   .cmp_val(cmp_val), .csr_we(csr_we), .fpr_we(fpr_we),
   .fpr_wdata(fpr_wdata), .gpr_we(gpr_we), .br_valid(br_valid),
   .br_taken(br_taken), .br_target(br_target),
   .slot_nullify(slot_nullify), .csr_out(csr_out));

// [tb/fmbc_pipe_model.sv]
// Pipeline model holding the register files that feed and take results.
`timescale 1ns/1ps
module fmbc_pipe_model
   import fmbc_pkg::*;
(
   // Clock
   input  wire logic              clk,
   // Destination lookup
   input  wire logic [REGA_W-1:0] issue_dst,
   output logic      [FPR_W-1:0]  fpr_dst_old,
   output logic      [GPR_W-1:0]  gpr_dst_old,
   // Write back
   input  wire logic              fpr_we,
   input  wire logic [REGA_W-1:0] fpr_waddr,
   input  wire logic [FPR_W-1:0]  fpr_wdata,
   input  wire logic              gpr_we,
   input  wire logic [REGA_W-1:0] gpr_waddr,
   input  wire logic [GPR_W-1:0]  gpr_wdata
);
   logic [FPR_W-1:0] fregs [32];
   logic [GPR_W-1:0] gregs [32];

   initial
   begin
      for (int i = 0; i < 32; i++)
      begin
         fregs[i] = {2{32'(32'h3f80_0000 + i)}};
         gregs[i] = 64'(i);
      end
   end

   assign fpr_dst_old = fregs[issue_dst];
   assign gpr_dst_old = gregs[issue_dst];

   always @(posedge clk)
   begin
      if (fpr_we)
         fregs[fpr_waddr] <= fpr_wdata;
      if (gpr_we)
         gregs[gpr_waddr] <= gpr_wdata;
   end
endmodule : fmbc_pipe_model

// [tb/fmbc_top_tb.sv]
// Self-checking random bench for the move and branch control block.
`timescale 1ns/1ps
module fmbc_top_tb
   import fmbc_pkg::*;
();
   logic clk = 0, nrst = 0, issue_valid = 0, cmp_we = 0, cmp_val = 0;
   logic csr_we = 0;
   fmbc_op_t issue_op = OP_NONE;
   fmbc_fmt_t issue_fmt = FMT_SINGLE, fpr_wfmt;
   logic [2:0] issue_cc_sel = '0, issue_align_offs = '0, cmp_sel = '0;
   logic [4:0] issue_dst = '0, fpr_waddr, gpr_waddr;
   logic [63:0] issue_pc = '0, fpr_src_a = '0, fpr_src_b = '0, gpr_test = '0;
   logic [63:0] gpr_src = '0, fpr_dst_old, gpr_dst_old, fpr_wdata, gpr_wdata;
   logic [63:0] br_target;
   logic [15:0] issue_offset = '0;
   logic [31:0] csr_wdata = '0, csr_out;
   logic fpr_we, gpr_we, br_valid, br_taken, slot_nullify;
   logic [7:0] cc_m = '0;
   logic sgn_m = 0;
   int n_fail = 0, check_count = 0;

   always #2.5 clk = ~clk;

   fmbc_top fmbc_top_inst (.clk(clk), .nrst(nrst), .issue_valid(issue_valid),
      .issue_op(issue_op), .issue_fmt(issue_fmt), .issue_cc_sel(issue_cc_sel),
      .issue_dst(issue_dst), .issue_align_offs(issue_align_offs),
      .issue_pc(issue_pc), .issue_offset(issue_offset),
      .fpr_src_a(fpr_src_a), .fpr_src_b(fpr_src_b), .fpr_dst_old(fpr_dst_old),
      .gpr_test(gpr_test), .gpr_src(gpr_src), .gpr_dst_old(gpr_dst_old),
      .cmp_we(cmp_we), .cmp_sel(cmp_sel), .cmp_val(cmp_val), .csr_we(csr_we),
      .csr_wdata(csr_wdata), .fpr_we(fpr_we), .fpr_waddr(fpr_waddr),
      .fpr_wdata(fpr_wdata), .fpr_wfmt(fpr_wfmt), .gpr_we(gpr_we),
      .gpr_waddr(gpr_waddr), .gpr_wdata(gpr_wdata), .br_valid(br_valid),
      .br_taken(br_taken), .br_target(br_target),
      .slot_nullify(slot_nullify), .csr_out(csr_out));

   fmbc_pipe_model fmbc_pipe_model_inst (.clk(clk), .issue_dst(issue_dst),
      .fpr_dst_old(fpr_dst_old), .gpr_dst_old(gpr_dst_old),
      .fpr_we(fpr_we), .fpr_waddr(fpr_waddr), .fpr_wdata(fpr_wdata),
      .gpr_we(gpr_we), .gpr_waddr(gpr_waddr), .gpr_wdata(gpr_wdata));

   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   // Expected write-back flag and data for the floating register file.
   function automatic logic [64:0] exp_fpr(fmbc_op_t op, logic c);
      logic [63:0] m, a, b, o;
      a = fpr_src_a;
      b = fpr_src_b;
      o = fpr_dst_old;
      m = issue_fmt == FMT_SINGLE ? 64'h8000_0000 : issue_fmt == FMT_PAIRED ?
          64'h8000_0000_8000_0000 : 64'h8000_0000_0000_0000;
      case (op)
         OP_FP_MOVE:          return {1'b1, a};
         OP_FP_ABS:           return {sgn_m, a & ~m};
         OP_FP_NEG:           return {sgn_m, a ^ m};
         OP_MOVE_CC_FALSE:    return {1'b1, c ? o : a};
         OP_MOVE_CC_TRUE:     return {1'b1, c ? a : o};
         OP_MOVE_GPR_NONZERO: return {1'b1, gpr_test != '0 ? a : o};
         OP_MOVE_GPR_ZERO:    return {1'b1, gpr_test == '0 ? a : o};
         OP_ALIGN_VARIABLE:
            return {1'b1, issue_align_offs == ALIGN_HALF_OFFS ?
                    {a[31:0], b[63:32]} : a};
         OP_PAIR_LL:          return {1'b1, a[31:0], b[31:0]};
         OP_PAIR_LU:          return {1'b1, a[31:0], b[63:32]};
         OP_PAIR_UL:          return {1'b1, a[63:32], b[31:0]};
         OP_PAIR_UU:          return {1'b1, a[63:32], b[63:32]};
         default:             return '0;
      endcase
   endfunction : exp_fpr

   task automatic set_csr(input logic [31:0] d);
      @(posedge clk);
      csr_we <= 1'b1;
      csr_wdata <= d;
      @(posedge clk);
      csr_we <= 1'b0;
      sgn_m = d[CSR_SIGN_POS];
      cc_m = {d[CSR_CC17_HI:CSR_CC17_LO], d[CSR_CC0_POS]};
   endtask : set_csr

   task automatic compare_write(input logic [2:0] s, input logic v);
      @(posedge clk);
      cmp_we <= 1'b1;
      cmp_sel <= s;
      cmp_val <= v;
      @(posedge clk);
      cmp_we <= 1'b0;
      cc_m[s] = v;
      @(posedge clk);
      #1;
      check({csr_out[CSR_CC17_HI:CSR_CC17_LO], csr_out[CSR_CC0_POS],
             csr_out[CSR_SIGN_POS]}, {cc_m, sgn_m});
   endtask : compare_write

   task automatic issue(input fmbc_op_t op);
      logic [64:0] e;
      logic [63:0] tgt;
      logic c, t;
      @(posedge clk);
      issue_valid <= 1'b1;
      issue_op <= op;
      // Moves only see formats they accept; merges only paired.
      issue_fmt <= op >= OP_ALIGN_VARIABLE || $urandom_range(0, 2) == 0 ?
                   FMT_PAIRED : fmbc_fmt_t'($urandom_range(0, 1));
      issue_cc_sel <= 3'($urandom);
      issue_dst <= 5'($urandom);
      issue_align_offs <= $urandom_range(0, 1) ? 3'h4 : 3'($urandom);
      issue_pc <= {$urandom, $urandom};
      issue_offset <= 16'($urandom);
      fpr_src_a <= {$urandom, $urandom};
      fpr_src_b <= {$urandom, $urandom};
      gpr_test <= $urandom_range(0, 1) ? 64'h0 : {$urandom, $urandom};
      gpr_src <= {$urandom, $urandom};
      #1;
      c = cc_m[issue_cc_sel];
      e = exp_fpr(op, c);
      t = op inside {OP_BRANCH_CC_TRUE, OP_BRANCH_LIKELY_TRUE} ? c : !c;
      tgt = issue_pc + 64'h4 + {{46{issue_offset[15]}}, issue_offset, 2'b00};
      @(posedge clk);
      issue_valid <= 1'b0;
      #1;
      if (e[64])
         check({fpr_we, fpr_wdata, fpr_waddr, fpr_wfmt},
               {e, issue_dst, issue_fmt});
      else
         check(fpr_we, 1'b0);
      if (op inside {[OP_BRANCH_CC_FALSE:OP_BRANCH_LIKELY_TRUE]})
      begin
         check({br_valid, br_taken}, {1'b1, t});
         check(slot_nullify, op >= OP_BRANCH_LIKELY_FALSE && !t);
         check(br_target, tgt);
      end
      else
         check(br_valid, 1'b0);
      if (op == OP_GPR_MOVE_CC_TRUE || op == OP_GPR_MOVE_CC_FALSE)
         check({gpr_we, gpr_waddr, gpr_wdata}, {1'b1, issue_dst,
               (c == (op == OP_GPR_MOVE_CC_TRUE)) ? gpr_src : gpr_dst_old});
      else
         check(gpr_we, 1'b0);
   endtask : issue

   initial
   begin
      #100000;
      n_fail++;
      give_verdict();
   end

   initial
   begin
      void'($urandom(32'h051b));
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      check(csr_out, CSR_RESET);
      for (int k = 0; k < 32; k++)
      begin
         set_csr($urandom);
         compare_write(3'(k), 1'($urandom));
         // Likely branches stay in the mix; avoiding them is advised only.
         for (int o = 0; o <= OP_PAIR_UU; o++)
            issue(fmbc_op_t'(o));
      end
      give_verdict();
   end
endmodule : fmbc_top_tb
